// ==== proximity_measure_sequencer.sv ====
`timescale 1ns/1ps
// Contract
// - Answer as link target only at seven-bit address 0x29.
// - Power-up bit 0 runs the oscillator; clearing stops it.
// - Enable bit 2 switches proximity measurement on or off.
// - Measurement runs only while power-up is also set.
// - Enable bit 3 turns the wait timer between measurements on or off.
// - Gap between measurements is 88 us times the interval value.
// - Wait counter counts down to zero: N gives N+1 steps of 2.81 ms.
// - Long-wait bit 2 makes each wait step twelve times longer.
// - Result below low limit counts toward filter, then sets flag.
// - Result above high limit counts toward filter, then sets flag.
// - Interrupt pin active while flag set and its mask bit enabled.
// - Filter 0 every cycle, 1 any out-of-range, N consecutive.
// - Status flags clear themselves once read.
// - Pulse config resets 0x4f, gain 0x80, wait config 0x80.
// - Interrupt pin is open drain, pulled low while pending.
module proximity_measure_sequencer #(
  parameter int INTERVAL_CYC = prox_seq_pkg::INTERVAL_CYC,
  parameter int WAIT_CYC = prox_seq_pkg::WAIT_CYC,
  parameter logic [7:0] REV_CODE = 8'h01,
  parameter logic [7:0] PART_CODE = 8'h5c
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic int_out,
  output logic int_oe_n,
  output logic osc_on,
  output logic meas_start,
  input wire logic [7:0] prox_data,
  input wire logic prox_done
);

  // REV_CODE and PART_CODE values are arbitrary
  if (INTERVAL_CYC < 1 || WAIT_CYC < 1) begin
    $error("Timing counts must be at least one");
  end
  // The long wait step must still fit the 32-bit step counter
  if (64'(WAIT_CYC) * prox_seq_pkg::LONG_FACTOR > 64'h7fffffff) begin
    $error("Wait step too long for the counter");
  end

  prox_seq_pkg::state_t r;
  prox_seq_pkg::state_t n;

  function automatic logic [7:0] read_reg(prox_seq_pkg::state_t s,
                                          logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == prox_seq_pkg::A_ENABLE) begin
      v = s.enable;
    end else if (a == prox_seq_pkg::A_SAMPLE_INTERVAL) begin
      v = s.sample_interval;
    end else if (a == prox_seq_pkg::A_DELAY_COUNT) begin
      v = s.delay_count;
    end else if (a == prox_seq_pkg::A_LOWER_LIMIT) begin
      v = s.lower_limit;
    end else if (a == prox_seq_pkg::A_UPPER_LIMIT) begin
      v = s.upper_limit;
    end else if (a == prox_seq_pkg::A_INTERRUPT_FILTER) begin
      v = s.interrupt_filter;
    end else if (a == prox_seq_pkg::A_DELAY_SCALE_CONFIG) begin
      v = s.delay_scale_config;
    end else if (a == prox_seq_pkg::A_REVISION_CODE) begin
      v = REV_CODE;
    end else if (a == prox_seq_pkg::A_PART_CODE) begin
      v = PART_CODE;
    end else if (a == prox_seq_pkg::A_STATUS) begin
      v = s.status;
    end else if (a == prox_seq_pkg::A_MEASUREMENT_RESULT) begin
      v = s.measurement_result;
    end else if (a == prox_seq_pkg::A_IRQ_MASK) begin
      v = s.irq_mask;
    end else begin
      for (int i = 0; i < prox_seq_pkg::SPARE_N; i++) begin
        if (a == prox_seq_pkg::SPARE_ADDR[i]) begin
          v = s.spare[i];
        end
      end
    end
    return v;
  endfunction

  // Writes to read-only, status and unmapped offsets are dropped
  function automatic prox_seq_pkg::state_t write_reg(
      prox_seq_pkg::state_t s, logic [7:0] a, logic [7:0] d);
    prox_seq_pkg::state_t t;
    t = s;
    if (a == prox_seq_pkg::A_ENABLE) begin
      t.enable = d;
    end else if (a == prox_seq_pkg::A_SAMPLE_INTERVAL) begin
      t.sample_interval = d;
    end else if (a == prox_seq_pkg::A_DELAY_COUNT) begin
      t.delay_count = d;
    end else if (a == prox_seq_pkg::A_LOWER_LIMIT) begin
      t.lower_limit = d;
    end else if (a == prox_seq_pkg::A_UPPER_LIMIT) begin
      t.upper_limit = d;
    end else if (a == prox_seq_pkg::A_INTERRUPT_FILTER) begin
      t.interrupt_filter = d;
    end else if (a == prox_seq_pkg::A_DELAY_SCALE_CONFIG) begin
      // Reserved bits are stored as written
      t.delay_scale_config = d;
    end else if (a == prox_seq_pkg::A_IRQ_MASK) begin
      t.irq_mask = d;
    end else begin
      for (int i = 0; i < prox_seq_pkg::SPARE_N; i++) begin
        if (a == prox_seq_pkg::SPARE_ADDR[i]) begin
          t.spare[i] = d;
        end
      end
    end
    return t;
  endfunction

  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic run;
    logic out_rng;
    logic hit;
    logic [3:0] need;
    logic [3:0] c;
    logic [7:0] rd;
    logic [31:0] wlen;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    run = 1'b0;
    out_rng = 1'b0;
    hit = 1'b0;
    need = 4'h0;
    c = 4'h0;
    rd = 8'h00;
    wlen = 32'h0;
    n = r;
    // Start is a single-cycle strobe
    n.meas_start = 1'b0;

    // Pins are asynchronous to clk_sys, so two stages before any use
    n.scl_m = scl;
    n.scl_s = r.scl_m;
    n.scl_q = r.scl_s;
    n.sda_m = sda_in;
    n.sda_s = r.sda_m;
    n.sda_q = r.sda_s;
    scl_rise = r.scl_s & ~r.scl_q;
    scl_fall = ~r.scl_s & r.scl_q;
    start_c = r.scl_s & r.scl_q & r.sda_q & ~r.sda_s;
    stop_c = r.scl_s & r.scl_q & ~r.sda_q & r.sda_s;
    rd = read_reg(r, r.ptr);

    // A start aborts any transfer, even one in mid byte
    if (start_c) begin
      n.i2c = prox_seq_pkg::I_ADDR;
      n.cnt = 4'h0;
      n.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      n.i2c = prox_seq_pkg::I_IDLE;
      n.sda_oe_n = 1'b1;
    end else begin
      case (r.i2c)
        prox_seq_pkg::I_ADDR, prox_seq_pkg::I_REG,
        prox_seq_pkg::I_WDATA: begin
          if (scl_rise && r.cnt < 4'h8) begin
            n.shreg = {r.shreg[6:0], r.sda_s};
            n.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == 4'h8) begin
            n.cnt = 4'h9;
            n.sda_oe_n = 1'b0;
            if (r.i2c == prox_seq_pkg::I_ADDR) begin
              n.rw = r.shreg[0];
              if (r.shreg[7:1] != prox_seq_pkg::DEV_ADDR) begin
                n.i2c = prox_seq_pkg::I_IDLE;
                n.sda_oe_n = 1'b1;
              end
            end else if (r.i2c == prox_seq_pkg::I_REG) begin
              n.ptr = r.shreg;
            end else begin
              n.ptr = r.ptr + 8'h01;
              n = write_reg(n, r.ptr, r.shreg);
            end
          end else if (scl_fall && r.cnt == 4'h9) begin
            n.cnt = 4'h0;
            n.sda_oe_n = 1'b1;
            if (r.i2c == prox_seq_pkg::I_ADDR && r.rw) begin
              n.i2c = prox_seq_pkg::I_RDATA;
              n.shreg = rd;
              n.sda_oe_n = rd[7];
              n.ptr = r.ptr + 8'h01;
              if (r.ptr == prox_seq_pkg::A_STATUS) begin
                n.status = 8'h00;
              end
            end else if (r.i2c == prox_seq_pkg::I_ADDR) begin
              n.i2c = prox_seq_pkg::I_REG;
            end else begin
              n.i2c = prox_seq_pkg::I_WDATA;
            end
          end
        end
        // Data moves only after the clock has fallen, never while high
        prox_seq_pkg::I_RDATA: begin
          if (scl_rise && r.cnt == 4'h8) begin
            n.mack = ~r.sda_s;
            n.cnt = 4'h9;
          end else if (scl_rise && r.cnt < 4'h8) begin
            n.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt >= 4'h1 && r.cnt <= 4'h7) begin
            n.shreg = {r.shreg[6:0], 1'b0};
            n.sda_oe_n = r.shreg[6];
          end else if (scl_fall && r.cnt == 4'h8) begin
            n.sda_oe_n = 1'b1;
          end else if (scl_fall && r.cnt == 4'h9) begin
            n.cnt = 4'h0;
            if (r.mack) begin
              n.shreg = rd;
              n.sda_oe_n = rd[7];
              n.ptr = r.ptr + 8'h01;
              if (r.ptr == prox_seq_pkg::A_STATUS) begin
                n.status = 8'h00;
              end
            end else begin
              n.i2c = prox_seq_pkg::I_IDLE;
              n.sda_oe_n = 1'b1;
            end
          end
        end
        default: begin
          n.sda_oe_n = 1'b1;
        end
      endcase
    end

    // Enable bits and the long-wait bit use this cycle's writes; limits, filter, interval and wait count use r
    run = n.enable[prox_seq_pkg::POWER_BIT] &
          n.enable[prox_seq_pkg::MEASURE_BIT];
    wlen = n.delay_scale_config[prox_seq_pkg::LONG_DELAY_BIT] ?
           32'(WAIT_CYC * prox_seq_pkg::LONG_FACTOR) :
           32'(WAIT_CYC);
    need = r.interrupt_filter[prox_seq_pkg::FILTER_LSB +: 4];
    out_rng = (prox_data < r.lower_limit) |
              (prox_data > r.upper_limit);

    if (!run) begin
      n.seq = prox_seq_pkg::S_IDLE;
      n.interrupt_filter_cnt = 4'h0;
    end else begin
      case (r.seq)
        prox_seq_pkg::S_IDLE: begin
          n.meas_start = 1'b1;
          n.seq = prox_seq_pkg::S_MEAS;
        end
        // No timeout: a converter that never answers stalls the sequence
        prox_seq_pkg::S_MEAS: begin
          if (prox_done) begin
            n.measurement_result = prox_data;
            if (need == 4'h0) begin
              hit = 1'b1;
            end else if (out_rng) begin
              c = (r.interrupt_filter_cnt == 4'hf) ? 4'hf : r.interrupt_filter_cnt + 4'h1;
              n.interrupt_filter_cnt = c;
              hit = (c >= need);
            end else begin
              n.interrupt_filter_cnt = 4'h0;
            end
            n.units = r.sample_interval;
            n.tick = 32'(INTERVAL_CYC - 1);
            n.seq = prox_seq_pkg::S_RATE;
          end
        end
        prox_seq_pkg::S_RATE: begin
          if (r.units == 8'h00) begin
            n.units = r.delay_count;
            n.tick = wlen - 32'h1;
            n.seq = n.enable[prox_seq_pkg::DELAY_EN_BIT] ?
                    prox_seq_pkg::S_WAIT : prox_seq_pkg::S_IDLE;
          end else if (r.tick == 32'h0) begin
            n.units = r.units - 8'h01;
            n.tick = 32'(INTERVAL_CYC - 1);
          end else begin
            n.tick = r.tick - 32'h1;
          end
        end
        default: begin
          // Terminal count zero still spends one full step
          if (r.tick == 32'h0) begin
            if (r.units == 8'h00) begin
              n.seq = prox_seq_pkg::S_IDLE;
            end else begin
              n.units = r.units - 8'h01;
              n.tick = wlen - 32'h1;
            end
          end else begin
            n.tick = r.tick - 32'h1;
          end
        end
      endcase
    end

    // Set after the read clear, so a new event is never lost
    if (hit) begin
      n.status[prox_seq_pkg::PROX_FLAG_BIT] = 1'b1;
    end
    n.int_oe_n = ~(n.status[prox_seq_pkg::PROX_FLAG_BIT] &
                   n.irq_mask[prox_seq_pkg::PROX_MASK_BIT]);
  end

  // Synchronisers reset to the idle-high bus level, so no false start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.scl_q <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
      r.sda_q <= 1'b1;
      r.i2c <= prox_seq_pkg::I_IDLE;
      r.sda_oe_n <= 1'b1;
      r.enable <= prox_seq_pkg::RST_ENABLE;
      r.sample_interval <= prox_seq_pkg::RST_SAMPLE_INTERVAL;
      r.delay_count <= prox_seq_pkg::RST_DELAY_COUNT;
      r.lower_limit <= prox_seq_pkg::RST_LOWER_LIMIT;
      r.upper_limit <= prox_seq_pkg::RST_UPPER_LIMIT;
      r.interrupt_filter <= prox_seq_pkg::RST_INTERRUPT_FILTER;
      r.delay_scale_config <= prox_seq_pkg::RST_DELAY_SCALE_CONFIG;
      r.status <= prox_seq_pkg::RST_STATUS;
      r.measurement_result <= prox_seq_pkg::RST_MEASUREMENT_RESULT;
      r.irq_mask <= prox_seq_pkg::RST_IRQ_MASK;
      r.spare <= prox_seq_pkg::SPARE_RST;
      r.seq <= prox_seq_pkg::S_IDLE;
      r.int_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Both pins are open drain: they only ever pull low
  assign sda_out = 1'b0;
  assign int_out = 1'b0;
  assign sda_oe_n = r.sda_oe_n;
  assign int_oe_n = r.int_oe_n;
  assign osc_on = r.enable[prox_seq_pkg::POWER_BIT];
  assign meas_start = r.meas_start;

endmodule

// ==== prox_seq_pkg.sv ====
package prox_seq_pkg;

  // Link address of the target
  localparam logic [6:0] DEV_ADDR = 7'h29;

  // Register offsets
  localparam logic [7:0] A_ENABLE = 8'h80;
  localparam logic [7:0] A_SAMPLE_INTERVAL = 8'h82;
  localparam logic [7:0] A_DELAY_COUNT = 8'h83;
  localparam logic [7:0] A_LOWER_LIMIT = 8'h88;
  localparam logic [7:0] A_UPPER_LIMIT = 8'h8a;
  localparam logic [7:0] A_INTERRUPT_FILTER = 8'h8c;
  localparam logic [7:0] A_DELAY_SCALE_CONFIG = 8'h8d;
  localparam logic [7:0] A_REVISION_CODE = 8'h91;
  localparam logic [7:0] A_PART_CODE = 8'h92;
  localparam logic [7:0] A_STATUS = 8'h93;
  localparam logic [7:0] A_MEASUREMENT_RESULT = 8'h9c;
  localparam logic [7:0] A_REVISION_AUX = 8'h9e;
  localparam logic [7:0] A_IRQ_MASK = 8'hdd;

  // Plain storage registers with no effect on the sequencer
  localparam int SPARE_N = 9;
  localparam logic [SPARE_N-1:0][7:0] SPARE_ADDR = {
    8'hdc, 8'hd9, 8'hd7, 8'hc1, 8'hc0, 8'hab, 8'h9f, 8'h8f, 8'h8e};
  localparam logic [SPARE_N-1:0][7:0] SPARE_RST = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h00, 8'h80, 8'h4f};

  // Reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_SAMPLE_INTERVAL = 8'h1f;
  localparam logic [7:0] RST_DELAY_COUNT = 8'h00;
  localparam logic [7:0] RST_LOWER_LIMIT = 8'h00;
  localparam logic [7:0] RST_UPPER_LIMIT = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_FILTER = 8'h00;
  localparam logic [7:0] RST_DELAY_SCALE_CONFIG = 8'h80;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MEASUREMENT_RESULT = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;

  // Field positions
  localparam int POWER_BIT = 0;
  localparam int MEASURE_BIT = 2;
  localparam int DELAY_EN_BIT = 3;
  localparam int LONG_DELAY_BIT = 2;
  localparam int FILTER_LSB = 4;
  localparam int PROX_FLAG_BIT = 5;
  localparam int PROX_MASK_BIT = 5;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int INTERVAL_NS = 88000;
  localparam int WAIT_STEP_NS = 2810000;
  localparam int LONG_FACTOR = 12;
  localparam int INTERVAL_CYC = INTERVAL_NS / CLK_PERIOD_NS;
  localparam int WAIT_CYC = WAIT_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_REG, I_WDATA, I_RDATA
  } i2c_st_t;

  typedef enum logic [1:0] {
    S_IDLE, S_MEAS, S_RATE, S_WAIT
  } seq_st_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_q;
    logic sda_m;
    logic sda_s;
    logic sda_q;
    i2c_st_t i2c;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic mack;
    logic [7:0] ptr;
    logic sda_oe_n;
    logic [7:0] enable;
    logic [7:0] sample_interval;
    logic [7:0] delay_count;
    logic [7:0] lower_limit;
    logic [7:0] upper_limit;
    logic [7:0] interrupt_filter;
    logic [7:0] delay_scale_config;
    logic [7:0] status;
    logic [7:0] measurement_result;
    logic [7:0] irq_mask;
    logic [SPARE_N-1:0][7:0] spare;
    seq_st_t seq;
    logic [7:0] units;
    logic [31:0] tick;
    logic [3:0] interrupt_filter_cnt;
    logic meas_start;
    logic int_oe_n;
  } state_t;

endpackage

// ==== prox_seq_checker.sv ====
`timescale 1ns/1ps
module prox_seq_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic int_out,
  input wire logic int_oe_n,
  input wire logic osc_on,
  input wire logic meas_start,
  input wire logic [7:0] prox_data,
  input wire logic prox_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_start_needs_power: assert property (
    meas_start |-> osc_on) else $error("start without power");
  a_start_one_cycle: assert property (
    meas_start |=> !meas_start) else $error("start pulse too long");
  a_start_min_gap: assert property (
    meas_start |=> !meas_start [*2]) else $error("starts too close");
  a_int_pin_low: assert property (
    !int_out) else $error("interrupt pin drives high");
  a_sda_pin_low: assert property (
    !sda_out) else $error("data pin drives high");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> sda_oe_n && int_oe_n && !osc_on && !meas_start)
    else $error("outputs active after reset");
  a_ack_scl_low: assert property (
    $fell(sda_oe_n) |-> !scl) else $error("data driven while clock high");
  a_sda_still_high: assert property (
    scl && $past(scl) |-> $stable(sda_oe_n))
    else $error("data moved while clock high");
  cover property (meas_start);
  cover property ($fell(int_oe_n));
  cover property ($fell(sda_oe_n));
endmodule

bind proximity_measure_sequencer prox_seq_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out),
  .int_oe_n(int_oe_n), .osc_on(osc_on), .meas_start(meas_start),
  .prox_data(prox_data), .prox_done(prox_done));

// ==== prox_host_model.sv ====
`timescale 1ns/1ps
// Link controller; a released data line floats to the pull-up level
module prox_host_model (
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Data moves only while the clock is low, 80 ns each phase
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    #80 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
                         output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, ack);
  endtask
  // Also serves as repeated start when entered with the clock low
  task automatic start();
    sda_rel = 1'b1;
    #80 scl = 1'b1;
    #80 sda_rel = 1'b0;
    #80 scl = 1'b0;
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    #80 scl = 1'b1;
    #80 sda_rel = 1'b1;
    #80;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] r, d,
                    output logic nak);
    logic [7:0] q;
    logic k;
    start();
    byte_io({a, 1'b0}, q, nak);
    byte_io(r, q, k);
    byte_io(d, q, k);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] r,
                    output logic [7:0] d);
    logic [7:0] q;
    logic k;
    start();
    byte_io({a, 1'b0}, q, k);
    byte_io(r, q, k);
    start();
    byte_io({a, 1'b1}, q, k);
    byte_io(8'hff, d, k);
    stop();
  endtask
endmodule

// ==== proximity_measure_sequencer_tb.sv ====
`timescale 1ns/1ps
module proximity_measure_sequencer_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic prox_done = 1'b0;
  logic [7:0] prox_data = 8'h00;
  logic scl, sda_rel, sda_out, sda_oe_n, int_out, int_oe_n, osc_on;
  logic meas_start;
  logic start_d = 1'b0;
  logic nak;
  logic [7:0] q;
  logic [7:0] resq[$];
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0, n_meas = 0, n_done = 0, t_last = 0, t_gap = 0, g0, g, b0;
  localparam logic [7:0] RA[13] = '{8'h80, 8'h82, 8'h83, 8'h88, 8'h8a,
    8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'h93, 8'h9c, 8'h9e, 8'he0};
  localparam logic [7:0] RV[13] = '{8'h00, 8'h1f, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h80, 8'h4f, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  wire sda = sda_rel & (sda_oe_n | sda_out);

  // Small counts keep the long wait scenarios short
  proximity_measure_sequencer #(.INTERVAL_CYC(4), .WAIT_CYC(6)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out),
    .int_oe_n(int_oe_n), .osc_on(osc_on), .meas_start(meas_start),
    .prox_data(prox_data), .prox_done(prox_done));
  prox_host_model u_host (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Converter: result two cycles after start; data churns otherwise
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    start_d <= meas_start;
    prox_done <= start_d;
    prox_data <= ~prox_data;
    if (start_d)
      prox_data <= (resq.size() > 0) ? resq.pop_front() : 8'h0f;
    if (prox_done)
      n_done <= n_done + 1;
    if (meas_start) begin
      t_gap <= cyc - t_last;
      t_last <= cyc;
      n_meas <= n_meas + 1;
    end
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] r, d);
    u_host.wr(prox_seq_pkg::DEV_ADDR, r, d, nak);
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    u_host.rd(prox_seq_pkg::DEV_ADDR, r, d);
  endtask
  task automatic gap(output int v);
    int b;
    b = n_meas;
    wait (n_meas >= b + 2);
    @(negedge clk_sys);
    v = t_gap;
  endtask
  // Results come from resq; the flag must appear at result number fire
  task automatic run(input logic [7:0] p, input int fire);
    int n;
    int b;
    n = resq.size();
    wr(8'h8c, p);
    b = n_done;
    wr(8'h80, 8'h05);
    for (int i = 1; i <= n; i++) begin
      wait (n_done >= b + i);
      repeat (3) @(negedge clk_sys);
      chk({7'h0, int_oe_n}, {7'h0, i < fire});
    end
    wr(8'h80, 8'h01);
    rd(8'h93, q);
    chk(q, 8'h20);
    rd(8'h93, q);
    chk(q, 8'h00);
    chk({7'h0, int_oe_n}, 8'h01);
    $display("Test filter %h done", p);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    for (int i = 0; i < 13; i++) begin
      rd(RA[i], q);
      chk(q, RV[i]);
    end
    chk({7'h0, osc_on}, 8'h00);
    $display("Test reset values done");
    u_host.wr(7'h2a, 8'h80, 8'h01, nak);
    chk({7'h0, nak}, 8'h01);
    rd(8'h80, q);
    chk(q, 8'h00);
    wr(8'h80, 8'h04);
    chk({7'h0, nak}, 8'h00);
    repeat (300) @(negedge clk_sys);
    chk(8'(n_meas), 8'h00);
    wr(8'h80, 8'h01);
    chk({7'h0, osc_on}, 8'h01);
    $display("Test address and power done");
    // Gap differences cancel the fixed converter latency
    wr(8'h82, 8'h00);
    wr(8'h80, 8'h05);
    gap(g0);
    wr(8'h82, 8'h02);
    gap(g);
    chk(8'(g - g0), 8'h08);
    wr(8'h82, 8'h00);
    wr(8'h83, 8'h01);
    wr(8'h80, 8'h0d);
    gap(g);
    chk(8'(g - g0), 8'h0c);
    wr(8'h8d, 8'h84);
    gap(g);
    chk(8'(g - g0), 8'h90);
    wr(8'h80, 8'h05);
    gap(g);
    chk(8'(g - g0), 8'h00);
    $display("Test timing done");
    wr(8'h80, 8'h01);
    wr(8'h8d, 8'h80);
    wr(8'h82, 8'h1f);
    wr(8'h88, 8'h0a);
    wr(8'h8a, 8'h14);
    wr(8'hdd, 8'h20);
    rd(8'h93, q);
    resq = '{8'h0f};
    run(8'h00, 1);
    resq = '{8'h1e};
    run(8'h10, 1);
    resq = '{8'h05, 8'h05};
    run(8'h20, 2);
    resq = '{8'h05, 8'h0f, 8'h05, 8'h05};
    run(8'h20, 4);
    // A pending flag stays off the pin until its mask bit is set
    wr(8'hdd, 8'h00);
    wr(8'h8c, 8'h10);
    resq = '{8'h1e};
    b0 = n_done;
    wr(8'h80, 8'h05);
    wait (n_done > b0);
    repeat (3) @(negedge clk_sys);
    chk({7'h0, int_oe_n}, 8'h01);
    wr(8'hdd, 8'h20);
    chk({7'h0, int_oe_n}, 8'h00);
    wr(8'h80, 8'h00);
    chk({7'h0, osc_on}, 8'h00);
    rd(8'h93, q);
    chk(q, 8'h20);
    chk({7'h0, int_oe_n}, 8'h01);
    $display("Test mask and power off done");
    tally_and_finish();
  end
endmodule
